// File: carriage_pkg.sv
// shared constants and types for the tape carriage skip control
package carriage_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int CTRL_NONIND_BIT  = 0;
  localparam int CTRL_HEADING_BIT = 1;
  localparam int CTRL_SKIP5_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register width, bit order given where it is packed
  localparam int STATUS_W = 16;

  // tape channel index into the brush vector (channel n sits at n-1)
  localparam int CH_FIRST_LINE = 0;
  localparam int CH_FIRST_BODY = 1;
  localparam int CH_TOTAL_LINE = 4;
  localparam int CH_OVERFLOW   = 11;
  localparam int CHANNELS      = 12;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // steps of the skip-stop clear sequence
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_DROP_LATCH,
    SEQ_DROP_CLUTCH,
    SEQ_DROP_RUN,
    SEQ_DROP_STOPS,
    SEQ_SET_RELEASE,
    SEQ_DROP_HOLD
  } clear_state_t;

endpackage

// File: skip_clear_sequencer.sv
// steps the ordered release of relays after a skip stop
`timescale 1ns/1ps
module skip_clear_sequencer
  import carriage_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic start,
  output logic      step_drop_run,
  output logic      step_drop_stops,
  output logic      step_set_release,
  output logic      step_drop_hold
);

  clear_state_t state;

  // one step per clock; a start while busy is ignored, stop relays are locked anyway
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= SEQ_IDLE;
    end else begin
      case (state)
        SEQ_IDLE:        state <= start ? SEQ_DROP_LATCH : SEQ_IDLE;
        SEQ_DROP_LATCH:  state <= SEQ_DROP_CLUTCH;
        SEQ_DROP_CLUTCH: state <= SEQ_DROP_RUN;
        SEQ_DROP_RUN:    state <= SEQ_DROP_STOPS;
        SEQ_DROP_STOPS:  state <= SEQ_SET_RELEASE;
        SEQ_SET_RELEASE: state <= SEQ_DROP_HOLD;
        default:         state <= SEQ_IDLE;
      endcase
    end
  end

  // step strobes decoded from the state
  assign step_drop_run    = (state == SEQ_DROP_RUN);
  assign step_drop_stops  = (state == SEQ_DROP_STOPS);
  assign step_set_release = (state == SEQ_SET_RELEASE);
  assign step_drop_hold   = (state == SEQ_DROP_HOLD);

endmodule

// File: carriage_reg_port.sv
// AHB-Lite slave holding the control and status registers
`timescale 1ns/1ps
module carriage_reg_port
  import carriage_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  input  wire logic [STATUS_W-1:0] status,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [2:0]          ctrl
);

  logic access;
  logic wr_pending;
  logic [7:0] wr_addr;

  // only transfers of a word are decoded; other sizes still answer OKAY
  assign access = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == 3'h2);

  // address phase: latch a write, or fetch read data so it stands in the data phase
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= 32'h0;
    end else begin
      wr_pending <= access & hwrite;
      wr_addr    <= haddr[7:0];
      if (access & ~hwrite) begin
        case (haddr[7:0])
          CTRL_OFFSET:   hrdata <= {29'h0, ctrl};
          STATUS_OFFSET: hrdata <= {{(32 - STATUS_W){1'b0}}, status};
          default:       hrdata <= 32'h0;
        endcase
      end
    end
  end

  // data phase of a write; unmapped writes are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr_pending && wr_addr == CTRL_OFFSET) begin
      ctrl <= hwdata[2:0];
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule

// File: tape_carriage_skip_control.sv
// tape-controlled carriage skip, overflow and heading control logic
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
//
// Summary of operation
// - channel 12 hole sets overflow sensed latches
// - pending sets at PM5 while a line lists
// - non-indicate sets at CB71 and CB22 if wired
// - non-indicate sets skip-to-1 and all-skips
// - all-skips sets run at CB34, drops release
// - overflow skip clutches at low speed
// - all-skips blocks the direct timing stop
// - channel 1 hole sets stop relays
// - stop clears latches in fixed order
// - program level 1 sets skip-to-total request
// - skip-to-total sets all-skips and brush block
// - high speed: clutch after interposer confirms
// - brush block ignores channels 1 and 2
// - all-skips inhibits printing, machine idles
// - channel 5 hole stops total-line skip
// - first card minor starts skip-to-1
// - skip-to-1 ignores all other channels
// - no overflow during any skip
// - heading cards print, programming suspended
// - heading: auto skip to 2, overflow to 2
// - with other order, pass 1 then stop
module tape_carriage_skip_control
  import carriage_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                carriage_cb,
  input  wire logic [CHANNELS-1:0] channel_hole,
  input  wire logic                cb22,
  input  wire logic                cb33,
  input  wire logic                cb34,
  input  wire logic                cb71,
  input  wire logic                pm5,
  input  wire logic                pm10,
  input  wire logic                line_listing,
  input  wire logic                program_level_1,
  input  wire logic                early_program_window,
  input  wire logic                first_body_minor_hub,
  input  wire logic                heading_card,
  input  wire logic                last_heading_done,
  input  wire logic                interposer_shifted,
  output logic                     clutch_magnet,
  output logic                     interposer_magnet,
  output logic                     print_drive_enable,
  output logic                     idle_cycle_request,
  output logic                     force_heading_list,
  output logic                     program_suspend
);

  logic [2:0] ctrl;
  logic nonind_cfg;
  logic heading_ctl;
  logic skip5_cfg;
  logic overflow_sensed_latch;
  logic overflow_companion_latch;
  logic overflow_pending_latch;
  logic overflow_nonindicate_ctl;
  logic skip_first_line_req;
  logic skip_first_body_req;
  logic skip_total_line_req;
  logic past_first_line;
  logic all_skips_latch;
  logic brush_block_latch;
  logic carriage_run_latch;
  logic stop_release_latch;
  logic high_speed_stop_a;
  logic high_speed_stop_b;
  logic stop_hold_relay;
  logic skip_clear_relay;
  logic sense_overflow;
  logic set_run;
  logic [CHANNELS-1:0] live_hole;
  logic other_order;
  logic stop_first;
  logic stop_body;
  logic stop_total;
  logic stop_direct;
  logic stop_pick;
  logic step_drop_run;
  logic step_drop_stops;
  logic step_set_release;
  logic step_drop_hold;
  logic [STATUS_W-1:0] status;

  assign nonind_cfg  = ctrl[CTRL_NONIND_BIT];
  assign heading_ctl = ctrl[CTRL_HEADING_BIT];
  assign skip5_cfg   = ctrl[CTRL_SKIP5_BIT];

  // status bits, msb first
  assign status = {past_first_line, skip_clear_relay, stop_hold_relay, high_speed_stop_b,
                   high_speed_stop_a, stop_release_latch, carriage_run_latch,
                   brush_block_latch, all_skips_latch, skip_total_line_req,
                   skip_first_body_req, skip_first_line_req, overflow_nonindicate_ctl,
                   overflow_pending_latch, overflow_companion_latch, overflow_sensed_latch};

  carriage_reg_port u_regs (
    .clk       (clk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .status    (status),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .ctrl      (ctrl)
  );

  skip_clear_sequencer u_seq (
    .clk              (clk),
    .reset            (reset),
    .start            (stop_pick),
    .step_drop_run    (step_drop_run),
    .step_drop_stops  (step_drop_stops),
    .step_set_release (step_set_release),
    .step_drop_hold   (step_drop_hold)
  );

  // a passing channel 12 hole counts only outside skips
  assign sense_overflow = carriage_cb & channel_hole[CH_OVERFLOW] & ~all_skips_latch;

  // overflow sensed and companion latches
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_sensed_latch    <= 1'b0;
      overflow_companion_latch <= 1'b0;
    end else if (sense_overflow) begin
      overflow_sensed_latch    <= 1'b1;
      overflow_companion_latch <= 1'b1;
    end else if (skip_clear_relay) begin
      overflow_sensed_latch    <= 1'b0;
      overflow_companion_latch <= 1'b0;
    end
  end

  // overflow pending, taken when the last line lists
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_pending_latch <= 1'b0;
    end else if (overflow_sensed_latch & line_listing & pm5) begin
      overflow_pending_latch <= 1'b1;
    end else if (skip_clear_relay) begin
      overflow_pending_latch <= 1'b0;
    end
  end

  // non-indicate control needs the output wired to the non-indicate input
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_nonindicate_ctl <= 1'b0;
    end else if (overflow_pending_latch & nonind_cfg & cb71 & cb22) begin
      overflow_nonindicate_ctl <= 1'b1;
    end else if (skip_clear_relay) begin
      overflow_nonindicate_ctl <= 1'b0;
    end
  end

  // skip-to-first-line: from overflow, or from the first card minor impulse
  always_ff @(posedge clk) begin
    if (reset) begin
      skip_first_line_req <= 1'b0;
    end else if ((overflow_nonindicate_ctl & pm10) | first_body_minor_hub) begin
      skip_first_line_req <= 1'b1;
    end else if (skip_clear_relay) begin
      skip_first_line_req <= 1'b0;
    end
  end

  // skip-to-first-body: overflow under heading control, or after last heading
  always_ff @(posedge clk) begin
    if (reset) begin
      skip_first_body_req <= 1'b0;
    end else if (heading_ctl & pm10 & (overflow_nonindicate_ctl | last_heading_done)) begin
      skip_first_body_req <= 1'b1;
    end else if (skip_clear_relay) begin
      skip_first_body_req <= 1'b0;
    end
  end

  // skip-to-total from program level 1 in the early window
  always_ff @(posedge clk) begin
    if (reset) begin
      skip_total_line_req <= 1'b0;
    end else if (skip5_cfg & program_level_1 & early_program_window) begin
      skip_total_line_req <= 1'b1;
    end else if (skip_clear_relay) begin
      skip_total_line_req <= 1'b0;
    end
  end

  // all-skips latch picks at CB33 from any skip order
  always_ff @(posedge clk) begin
    if (reset) begin
      all_skips_latch <= 1'b0;
    end else if (cb33 & (overflow_nonindicate_ctl | skip_first_line_req |
                         skip_first_body_req | skip_total_line_req)) begin
      all_skips_latch <= 1'b1;
    end else if (skip_clear_relay) begin
      all_skips_latch <= 1'b0;
    end
  end

  // brush block rides with the total-line skip
  always_ff @(posedge clk) begin
    if (reset) begin
      brush_block_latch <= 1'b0;
    end else if (cb33 & skip_total_line_req) begin
      brush_block_latch <= 1'b1;
    end else if (skip_clear_relay) begin
      brush_block_latch <= 1'b0;
    end
  end

  assign other_order = skip_first_body_req | skip_total_line_req;

  // channel 1 passed on the way to another stop
  always_ff @(posedge clk) begin
    if (reset) begin
      past_first_line <= 1'b0;
    end else if (carriage_run_latch & carriage_cb & skip_first_line_req & other_order &
                 live_hole[CH_FIRST_LINE]) begin
      past_first_line <= 1'b1;
    end else if (skip_clear_relay) begin
      past_first_line <= 1'b0;
    end
  end

  // run latch at CB34; its pick drops the stop-release latch
  assign set_run = all_skips_latch & cb34 & ~skip_clear_relay;

  always_ff @(posedge clk) begin
    if (reset) begin
      carriage_run_latch <= 1'b0;
    end else if (set_run) begin
      carriage_run_latch <= 1'b1;
    end else if (step_drop_run) begin
      carriage_run_latch <= 1'b0;
    end
  end

  // release latch rests picked so the stop relays can hold later
  always_ff @(posedge clk) begin
    if (reset) begin
      stop_release_latch <= 1'b1;
    end else if (set_run) begin
      stop_release_latch <= 1'b0;
    end else if (step_set_release) begin
      stop_release_latch <= 1'b1;
    end
  end

  // brushes 1 and 2 are dead while the brush block is set
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_hole
      if (ch == CH_FIRST_LINE || ch == CH_FIRST_BODY) begin : g_blk
        assign live_hole[ch] = channel_hole[ch] & ~brush_block_latch;
      end else begin : g_pass
        assign live_hole[ch] = channel_hole[ch];
      end
    end
  endgenerate

  // stop selection; skip-to-1 alone hears only channel 1
  assign stop_first  = skip_first_line_req & ~other_order & live_hole[CH_FIRST_LINE];
  assign stop_body   = skip_first_body_req & (~skip_first_line_req | past_first_line) &
                       live_hole[CH_FIRST_BODY];
  assign stop_total  = skip_total_line_req & (~skip_first_line_req | past_first_line) &
                       live_hole[CH_TOTAL_LINE];
  assign stop_direct = ~all_skips_latch;
  assign stop_pick   = carriage_cb & carriage_run_latch & ~high_speed_stop_a &
                       (stop_direct | stop_first | stop_body | stop_total);

  // stop relays, stop-hold and skip-clear pick together
  always_ff @(posedge clk) begin
    if (reset) begin
      high_speed_stop_a <= 1'b0;
      high_speed_stop_b <= 1'b0;
    end else if (stop_pick) begin
      high_speed_stop_a <= 1'b1;
      high_speed_stop_b <= 1'b1;
    end else if (step_drop_stops) begin
      high_speed_stop_a <= 1'b0;
      high_speed_stop_b <= 1'b0;
    end
  end

  // stop-hold and skip-clear drop one step after the release latch comes back
  always_ff @(posedge clk) begin
    if (reset) begin
      stop_hold_relay  <= 1'b0;
      skip_clear_relay <= 1'b0;
    end else if (stop_pick) begin
      stop_hold_relay  <= 1'b1;
      skip_clear_relay <= 1'b1;
    end else if (step_drop_hold) begin
      stop_hold_relay  <= 1'b0;
      skip_clear_relay <= 1'b0;
    end
  end

  // overflow skip runs at low speed; others shift the interposer first
  always_ff @(posedge clk) begin
    if (reset) begin
      interposer_magnet <= 1'b0;
      clutch_magnet     <= 1'b0;
    end else begin
      interposer_magnet <= all_skips_latch & carriage_run_latch & ~overflow_companion_latch &
                           ~high_speed_stop_a;
      clutch_magnet     <= all_skips_latch & carriage_run_latch & ~high_speed_stop_a &
                           (overflow_companion_latch |
                            (interposer_magnet & interposer_shifted));
    end
  end

  // printing held off for the whole skip so nothing prints in flight
  always_ff @(posedge clk) begin
    if (reset) begin
      print_drive_enable <= 1'b0;
      idle_cycle_request <= 1'b0;
    end else begin
      print_drive_enable <= ~all_skips_latch;
      idle_cycle_request <= all_skips_latch;
    end
  end

  // heading cards list and hold programming off only while heading control is set
  always_ff @(posedge clk) begin
    if (reset) begin
      force_heading_list <= 1'b0;
      program_suspend    <= 1'b0;
    end else begin
      force_heading_list <= heading_ctl & heading_card;
      program_suspend    <= heading_ctl & heading_card;
    end
  end

  default clocking cb_main @(posedge clk); endclocking
  default disable iff (reset);

  a_overflow_sense: assert property (
    sense_overflow |=> overflow_sensed_latch && overflow_companion_latch)
    else $error("overflow latches missed a channel 12 hole");

  a_pending_cause: assert property (
    $rose(overflow_pending_latch) |-> $past(overflow_sensed_latch & line_listing & pm5))
    else $error("overflow pending set without cause");

  a_nonind_wired: assert property (
    $rose(overflow_nonindicate_ctl) |-> $past(nonind_cfg & cb71 & cb22))
    else $error("non-indicate set without wiring or timing");

  a_release_drop: assert property (
    $rose(carriage_run_latch) |-> !stop_release_latch)
    else $error("stop release still held after run pick");

  a_overflow_low: assert property (
    overflow_companion_latch && $past(overflow_companion_latch) |-> !interposer_magnet)
    else $error("interposer engaged on overflow skip");

  a_clutch_shift: assert property (
    $rose(clutch_magnet) && !$past(overflow_companion_latch) |-> $past(interposer_shifted))
    else $error("clutch before interposer shift");

  a_print_block: assert property (
    all_skips_latch |=> !print_drive_enable && idle_cycle_request)
    else $error("printing not inhibited during skip");

  a_clear_order: assert property (
    $rose(skip_clear_relay) |-> ##3 !carriage_run_latch ##1 !high_speed_stop_a
                               ##1 stop_release_latch ##1 !skip_clear_relay)
    else $error("clear sequence out of order");

  a_skip_cleared: assert property (
    skip_clear_relay && !cb33 |=> !all_skips_latch)
    else $error("all-skips not cleared by skip clear");

  a_no_ovf_skip: assert property (
    all_skips_latch && !overflow_sensed_latch |=> !overflow_sensed_latch)
    else $error("overflow sensed during a skip");

endmodule

// File: machine_cycle_model.sv
// cam timing model of the print, program and list side of the machine
`timescale 1ns/1ps
module machine_cycle_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic print_drive_enable,
  output logic      pm5,
  output logic      pm10,
  output logic      cb22,
  output logic      cb33,
  output logic      cb34,
  output logic      cb71,
  output logic      line_listing
);
  logic [3:0] phase;

  // free running cam index, one machine cycle every 16 clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // cam points close once a cycle, always in the same order
  assign pm5  = (phase == 4'h2);
  assign cb71 = (phase == 4'h4);
  assign cb22 = (phase == 4'h4); // taken together with cb71
  assign pm10 = (phase == 4'h6);
  assign cb33 = (phase == 4'h8);
  assign cb34 = (phase == 4'ha);

  // no listing while printing is held off, so the machine idles through a skip
  assign line_listing = print_drive_enable;
endmodule

// File: tape_carriage_skip_control_tb.sv
// self-checking bench for the tape carriage skip control
`timescale 1ns/1ps
module tape_carriage_skip_control_tb;
  import carriage_pkg::*;
  localparam logic [31:0] CT = {24'h0, CTRL_OFFSET};
  localparam logic [31:0] ST = {24'h0, STATUS_OFFSET};
  logic                clk, reset, hsel, hwrite, hreadyout, hresp, carriage_cb;
  logic                cb22, cb33, cb34, cb71, pm5, pm10, line_listing, program_level_1;
  logic                early_program_window, first_body_minor_hub, heading_card;
  logic                last_heading_done, interposer_shifted, clutch_magnet;
  logic                interposer_magnet, print_drive_enable, idle_cycle_request;
  logic                force_heading_list, program_suspend;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [CHANNELS-1:0] channel_hole;
  int                  miscompares, comparisons;

  tape_carriage_skip_control u_dut (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .carriage_cb, .channel_hole,
    .cb22, .cb33, .cb34, .cb71, .pm5, .pm10, .line_listing, .program_level_1,
    .early_program_window, .first_body_minor_hub, .heading_card, .last_heading_done,
    .interposer_shifted, .clutch_magnet, .interposer_magnet, .print_drive_enable,
    .idle_cycle_request, .force_heading_list, .program_suspend
  );

  machine_cycle_model u_cams (
    .clk, .reset, .print_drive_enable, .pm5, .pm10, .cb22, .cb33, .cb34, .cb71,
    .line_listing
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single word transfer; the master waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // poll status until it settles on the expected word, bounded
  task automatic wait_st(input logic [31:0] exp);
    xfer(1'b0, ST, 32'h0);
    for (int i = 0; i < 40 && rd !== exp; i++) begin
      xfer(1'b0, ST, 32'h0);
    end
    chk(rd, exp);
  endtask

  // outputs are polled on falling edges until they match; a value that already matches on entry is taken at once
  task automatic wait_clutch(input logic v);
    for (int i = 0; i < 80 && clutch_magnet !== v; i++) @(negedge clk);
    chk({31'h0, clutch_magnet}, {31'h0, v});
  endtask

  // one carriage timing pulse with the given holes under the brushes
  task automatic sense(input logic [CHANNELS-1:0] holes);
    @(posedge clk);
    channel_hole <= holes;
    carriage_cb  <= 1'b1;
    @(posedge clk);
    channel_hole <= '0;
    carriage_cb  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic prog_l1;
    @(posedge clk);
    program_level_1      <= 1'b1;
    early_program_window <= 1'b1;
    @(posedge clk);
    program_level_1      <= 1'b0;
    early_program_window <= 1'b0;
  endtask

  // high speed start: clutch must wait for the interposer contact
  task automatic hs_go;
    for (int i = 0; i < 80 && interposer_magnet !== 1'b1; i++) @(negedge clk);
    chk({31'h0, interposer_magnet}, 32'h1);
    chk({31'h0, clutch_magnet}, 32'h0);
    chk({31'h0, print_drive_enable}, 32'h0);
    @(posedge clk);
    interposer_shifted <= 1'b1;
    wait_clutch(1'b1);
  endtask

  // interposer contact falls back just after a rising edge, like every other input
  task automatic stop_done;
    wait_st(32'h0400);
    @(negedge clk);
    chk({30'h0, clutch_magnet, print_drive_enable}, 32'h1);
    @(posedge clk);
    interposer_shifted <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    carriage_cb = 1'b0;
    channel_hole = '0;
    program_level_1 = 1'b0;
    early_program_window = 1'b0;
    first_body_minor_hub = 1'b0;
    heading_card = 1'b0;
    last_heading_done = 1'b0;
    interposer_shifted = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    // reset values, read-only status, unmapped place, control read back
    xfer(1'b0, CT, 32'h0);
    chk(rd, {29'h0, CTRL_RESET});
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    xfer(1'b1, ST, 32'hffff);
    wait_st(32'h0400);
    xfer(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, CT, 32'h7);
    xfer(1'b0, CT, 32'h0);
    chk(rd, 32'h7);
    // a byte-sized write is not decoded and must leave control alone
    hsize <= 3'h0;
    xfer(1'b1, CT, 32'h0);
    hsize <= 3'h2;
    xfer(1'b0, CT, 32'h0);
    chk(rd, 32'h7);
    xfer(1'b1, CT, 32'h0);
    // program level 1 with skip-to-5 unwired does nothing
    prog_l1();
    repeat (20) @(posedge clk);
    wait_st(32'h0400);
    // overflow sensed while non-indicate is unwired: pending but no skip
    sense(12'h800);
    wait_st(32'h0407);
    repeat (40) @(posedge clk);
    wait_st(32'h0407);
    // wiring non-indicate lets the overflow skip to channel 1 at low speed
    xfer(1'b1, CT, 32'h1);
    wait_clutch(1'b1);
    chk({31'h0, interposer_magnet}, 32'h0);
    chk({30'h0, print_drive_enable, idle_cycle_request}, 32'h1);
    wait_st(32'h029f);
    sense(12'h012);
    wait_clutch(1'b1);
    sense(12'h001);
    stop_done();
    // skip to the total line at high speed
    xfer(1'b1, CT, 32'h4);
    prog_l1();
    hs_go();
    wait_st(32'h03c0);
    sense(12'h003);
    wait_clutch(1'b1);
    sense(12'h800);
    wait_st(32'h03c0);
    sense(12'h010);
    stop_done();
    // skip to the first line from the first card minor source
    @(posedge clk);
    first_body_minor_hub <= 1'b1;
    @(posedge clk);
    first_body_minor_hub <= 1'b0;
    hs_go();
    wait_st(32'h0290);
    sense(12'h012);
    wait_clutch(1'b1);
    sense(12'h001);
    stop_done();
    // with heading control set, heading cards list and hold programming off
    xfer(1'b1, CT, 32'h2);
    @(posedge clk);
    heading_card <= 1'b1;
    repeat (3) @(negedge clk);
    chk({30'h0, force_heading_list, program_suspend}, 32'h3);
    @(posedge clk);
    heading_card <= 1'b0;
    repeat (3) @(negedge clk);
    chk({30'h0, force_heading_list, program_suspend}, 32'h0);
    // last heading line done: high speed skip to channel 2, channel 1 does not stop it
    @(posedge clk);
    last_heading_done <= 1'b1;
    repeat (16) @(posedge clk);
    last_heading_done <= 1'b0;
    hs_go();
    wait_st(32'h02a0);
    sense(12'h001);
    wait_clutch(1'b1);
    sense(12'h002);
    stop_done();
    // heading overflow: passes channel 1 first, then stops on channel 2 at low speed
    xfer(1'b1, CT, 32'h3);
    sense(12'h800);
    wait_clutch(1'b1);
    wait_st(32'h02bf);
    sense(12'h001);
    wait_st(32'h82bf);
    sense(12'h002);
    stop_done();
    print_verdict();
  end
endmodule
